//--- rtl/scfd_pkg.sv
// Constants and types shared by the special control field decoder.
package scfd_pkg;

	// Microword layout, bit 0 is the leftmost bit
	localparam int MW_WIDTH       = 48;
	localparam int RF_WRITE_BIT   = 26;
	localparam int Q_LOAD_BIT     = 27;
	localparam int A_FIRST        = 35;
	localparam int A_LAST         = 37;
	localparam int B_FIRST        = 38;
	localparam int B_LAST         = 41;
	localparam int C_FIRST        = 42;
	localparam int C_LAST         = 44;
	localparam int D_FIRST        = 45;
	localparam int D_LAST         = 47;
	localparam int CONST_SEL_BIT  = 38;
	localparam int CONST_FILL_BIT = 39;
	localparam int CONST_FIRST    = 40;
	localparam int CONST_LAST     = 47;
	localparam int USER_FIRST     = 38;
	localparam int USER_LAST      = 47;

	// A-field modes
	localparam logic [2:0] A_GENERAL    = 3'h0;
	localparam logic [2:0] A_MMU        = 3'h1;
	localparam logic [2:0] A_INDICATOR  = 3'h2;
	localparam logic [2:0] A_SHIFT      = 3'h3;
	localparam logic [2:0] A_CONSTANT   = 3'h4;
	localparam logic [2:0] A_USER_FIRST = 3'h5;

	// D-field codes in general and memory-management modes
	localparam logic [2:0] D_CLEAR_FLAG_THREE    = 3'h5;
	localparam logic [2:0] D_SET_FLAG_THREE      = 3'h6;
	localparam logic [2:0] D_CLEAR_OVERFLOW_TRAP = 3'h7;

	// General B codes that inhibit the C and D fields
	localparam logic [3:0] B_GEN_INHIBIT_5 = 4'h5;
	localparam logic [3:0] B_GEN_INHIBIT_7 = 4'h7;
	localparam logic [3:0] B_GEN_INHIBIT_D = 4'hD;
	localparam logic [3:0] B_GEN_INHIBIT_F = 4'hF;

	// Memory-management B-field codes
	localparam logic [3:0] B_CLEAR_TRANSLATION_ERRORS = 4'h0;
	localparam logic [3:0] B_LOAD_DESCRIPTOR_INDEX    = 4'h1;
	localparam logic [3:0] B_COPY_CURRENT_RING        = 4'h2;
	localparam logic [3:0] B_LOAD_BOTH_RINGS          = 4'h3;
	localparam logic [3:0] B_WRITE_BASE_WORD          = 4'h4;
	localparam logic [3:0] B_READ_BASE_WORD           = 4'h5;
	localparam logic [3:0] B_WRITE_SIZE_WORD          = 4'h6;
	localparam logic [3:0] B_READ_SIZE_WORD           = 4'h7;

	// Shift-mode B-field codes
	localparam logic [3:0] B_OPCODE_SHIFT_IND_CLEAR = 4'h0;
	localparam logic [3:0] B_FREG_Q_SHIFT           = 4'h1;
	localparam logic [3:0] B_OPCODE_SINGLE_SHIFT    = 4'h2;
	localparam logic [3:0] B_OPCODE_DOUBLE_SHIFT    = 4'h3;
	localparam logic [3:0] B_FW_Q_SHIFT             = 4'h5;
	localparam logic [3:0] B_FW_RF_SHIFT            = 4'h6;
	localparam logic [3:0] B_FW_DOUBLE_SHIFT        = 4'h7;

	// Shift kinds, same code as the C-field
	localparam logic [2:0] SHIFT_OPEN_LEFT   = 3'h0;
	localparam logic [2:0] SHIFT_ARITH_LEFT  = 3'h2;
	localparam logic [2:0] SHIFT_OPEN_RIGHT  = 3'h4;
	localparam logic [2:0] SHIFT_ARITH_RIGHT = 3'h6;
	localparam int         SHIFT_RIGHT_BIT   = 2;
	localparam logic [1:0] SHIFT_ARITH_TYPE  = 2'h2;

	// Indicator register bit positions
	localparam int IND_OVERFLOW  = 0;
	localparam int IND_CARRY     = 2;
	localparam int IND_BIT       = 3;
	localparam int IND_IO        = 4;
	localparam int IND_GREATER   = 5;
	localparam int IND_LESS      = 6;
	localparam int IND_UNORDERED = 7;

	// Sizes and reset values
	localparam int          DESC_DEPTH       = 32;
	localparam logic [0:7]  INDICATORS_RESET = 8'h00;
	localparam logic [1:0]  RING_RESET       = 2'h0;
	localparam logic [0:4]  DESC_INDEX_RESET = 5'h00;
	localparam logic [3:0]  MMU_ERRORS_RESET = 4'h0;
	localparam logic [0:15] WORD_RESET       = 16'h0000;

	typedef struct packed {
		logic [0:3]  ext;
		logic [0:15] data;
	} scfd_bus_type;

	typedef struct packed {
		logic greater;
		logic less;
		logic unordered;
	} scfd_compare_type;

	typedef enum logic [2:0] {
		OP_SOL, OP_SOR, OP_SAL, OP_SAR, OP_DOL, OP_DOR, OP_DAL, OP_DAR
	} scfd_opshift_type;

endpackage : scfd_pkg

//--- rtl/scfd_shifter.sv
// One-position shifter for single and concatenated double words.
`timescale 1ns/1ps
module scfd_shifter
	import scfd_pkg::*;
(
	// Operands
	input  wire logic [0:15] hi,
	input  wire logic [0:15] lo,
	input  wire logic        double_word,
	// Control
	input  wire logic [2:0]  kind,
	input  wire logic        filler,
	// Results
	output logic      [0:15] res_hi,
	output logic      [0:15] res_lo,
	output logic             bit_out,
	output logic             sign_change
);

	logic closed;
	logic arith;
	logic fill;

	always_comb begin
		closed      = kind[0];
		arith       = (kind[1:0] == SHIFT_ARITH_TYPE);
		fill        = filler;
		res_hi      = hi;
		res_lo      = lo;
		bit_out     = 1'b0;
		sign_change = 1'b0;
		if (!kind[SHIFT_RIGHT_BIT]) begin
			bit_out     = hi[0];
			sign_change = arith & (hi[0] ^ hi[1]);
			if (closed) begin
				fill = hi[0];
			end
			if (double_word) begin
				res_hi = {hi[1:15], lo[0]};
				res_lo = {lo[1:15], fill};
			end else begin
				res_hi = {hi[1:15], fill};
			end
		end else begin
			bit_out = double_word ? lo[15] : hi[15];
			if (closed) begin
				fill = bit_out;
			end else if (arith) begin
				// Sign is replicated, the filler is ignored
				fill = hi[0];
			end
			res_hi = {fill, hi[0:14]};
			if (double_word) begin
				res_lo = {hi[15], lo[0:14]};
			end
		end
	end

endmodule : scfd_shifter

//--- rtl/scfd_decoder.sv
// Special control field decoder: modes, indicators, shifts, constants, user codes.
//
// Summary of operation
// RULE_01 - General D-field 5 clears flag three, 6 sets it, 7 clears overflow trap.
// RULE_02 - MMU B 0 clears translation errors; 8-F nothing; C/D as general.
// RULE_03 - MMU B 1 loads descriptor index from bus extension or bus bits 00-03.
// RULE_04 - MMU B 2 copies current ring into effective ring.
// RULE_05 - MMU B 3 loads both rings from bus bits 01,02.
// RULE_06 - MMU B 4 writes bus into base word; 5 drives base word onto bus.
// RULE_07 - MMU B 6/7 write/read size word, then increment descriptor index.
// RULE_08 - Indicator B 1/2 clear/set overflow, 5/6 carry, 4 loads both from ALU.
// RULE_09 - Indicator B 3 loads bit indicator from bus 00; 7 from bus nonzero.
// RULE_10 - Indicator B 8/C load compare bits; 9,A,D,E clear/set.
// RULE_11 - Indicator B/F clear/set io indicator; C and D fields suppressed.
// RULE_12 - Shift B 0 clears overflow if arithmetic left, else carry.
// RULE_13 - Shift B 2 opcode single shift sets overflow and carry.
// RULE_14 - Shift B 3 opcode double shift of register file and Q.
// RULE_15 - Firmware keeps C and D zero for shift B 0-4; B 1 F-driven Q shift.
// RULE_16 - Firmware shift C-field gives direction and shift type.
// RULE_17 - Firmware enables Q load for B 5, register write for 6, both for 7.
// RULE_18 - For B 5-7 and C 0,2,4 the D-field selects the shift filler bit.
// RULE_19 - Shift B 8-F suppress all C-field and D-field operations.
// RULE_20 - Register-file shifts store the shifted ALU output.
// RULE_21 - Constant mode: bit 38 byte select, bit 39 other byte fill, 40-47 constant.
// RULE_22 - Constant mode copies bus bit 00 into the extension bits.
// RULE_23 - A-field 5-7 put bits 38-47 off chip with no internal action.
// RULE_24 - Special control field in bits 35-47; A-field 35-37 selects the mode.
// RULE_25 - Microword bit 26 enables register-file writes; else no change.
// RULE_26 - Microword bit 27 enables Q loading; no shift loads Q from bus.
// RULE_27 - B-field is bits 38-41, C-field 42-44, D-field 45-47.
`timescale 1ns/1ps
module scfd_decoder
	import scfd_pkg::*;
(
	// Clock and reset
	input  wire logic             CLOCK,
	input  wire logic             RST,
	input  wire logic             CE,
	// Microword from external store
	input  wire logic [0:47]      MICROWORD_BITS,
	// Datapath inputs on the processor clock
	input  wire scfd_bus_type     INTERNAL_BUS,
	input  wire scfd_bus_type     ALU_OUT,
	input  wire logic             ALU_CARRY16,
	input  wire logic             ALU_OVERFLOW16,
	input  wire scfd_compare_type COMPARE_16,
	input  wire scfd_compare_type COMPARE_20,
	input  wire scfd_opshift_type SHIFT_OPCODE,
	input  wire logic [2:0]       FREG_SHIFT_KIND,
	input  wire logic             CONTROL_FLAG_ONE,
	input  wire logic             CONTROL_FLAG_FOUR,
	// Event inputs from other logic
	input  wire logic             OVERFLOW_TRAP_SET,
	input  wire logic [3:0]       TRANSLATION_ERROR_SET,
	// Register file write port
	output logic                  RF_WRITE,
	output logic      [0:15]      RF_WRITE_DATA,
	// Q register
	output logic      [0:15]      Q_REGISTER,
	// Internal bus source
	output logic                  BUS_OUT_VALID,
	output scfd_bus_type          BUS_OUT,
	// Flags and indicators
	output logic      [0:7]       INDICATORS,
	output logic                  FLAG_THREE,
	output logic                  OVERFLOW_TRAP,
	output logic      [3:0]       TRANSLATION_ERRORS,
	// Memory-management state
	output logic      [1:0]       CURRENT_RING,
	output logic      [1:0]       EFFECTIVE_RING,
	output logic      [0:4]       DESCRIPTOR_INDEX,
	// User codes
	output logic                  USER_CODE_VALID,
	output logic      [0:9]       USER_CODE
);

	logic [0:47] mw_meta;
	logic [0:47] mw;
	logic [2:0]  a_field;
	logic [3:0]  b_field;
	logic [2:0]  c_field;
	logic [2:0]  d_field;
	logic        regfile_write_enable;
	logic        q_load_enable;
	logic        in_general;
	logic        in_mmu;
	logic        in_indicator;
	logic        in_shift;
	logic        in_constant;
	logic        in_user;
	logic        cd_inhibit;
	logic        d_active;
	logic        opcode_single_shift;
	logic        opcode_double_shift;
	logic        fw_q_shift;
	logic        fw_rf_shift;
	logic        fw_double_shift;
	logic        freg_q_shift;
	logic        q_shift;
	logic        rf_shift;
	logic        op_arith_left;
	logic        op_double;
	logic [2:0]  op_kind;
	logic [0:15] sh_hi;
	logic [0:15] sh_lo;
	logic        sh_double;
	logic [2:0]  sh_kind;
	logic        sh_filler;
	logic        shift_filler;
	logic [0:15] res_hi;
	logic [0:15] res_lo;
	logic        bit_out;
	logic        sign_change;
	logic [0:31] descriptor_file [DESC_DEPTH];
	logic [0:15] constant_word;

	// Two stages because the microword arrives from off-chip store
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			mw_meta <= '0;
			mw      <= '0;
		end else if (CE) begin
			mw_meta <= MICROWORD_BITS;
			mw      <= mw_meta;
		end
	end

	assign a_field              = mw[A_FIRST:A_LAST]; // RULE_24
	assign b_field              = mw[B_FIRST:B_LAST]; // RULE_27
	assign c_field              = mw[C_FIRST:C_LAST]; // RULE_27
	assign d_field              = mw[D_FIRST:D_LAST]; // RULE_27
	assign regfile_write_enable = mw[RF_WRITE_BIT];
	assign q_load_enable        = mw[Q_LOAD_BIT];

	assign in_general   = (a_field == A_GENERAL);
	assign in_mmu       = (a_field == A_MMU);
	assign in_indicator = (a_field == A_INDICATOR);
	assign in_shift     = (a_field == A_SHIFT);
	assign in_constant  = (a_field == A_CONSTANT);
	assign in_user      = (a_field >= A_USER_FIRST); // RULE_23

	// General B codes 5,7,D,F also mask the C and D fields
	assign cd_inhibit = in_indicator // RULE_11
		| (in_shift & b_field[3]) // RULE_19
		| (in_general & ((b_field == B_GEN_INHIBIT_5) | (b_field == B_GEN_INHIBIT_7)
			| (b_field == B_GEN_INHIBIT_D) | (b_field == B_GEN_INHIBIT_F)));
	assign d_active = (in_general | in_mmu) & ~cd_inhibit; // RULE_02

	// Shifts need their matching write enables
	assign opcode_single_shift = in_shift & (b_field == B_OPCODE_SINGLE_SHIFT)
		& regfile_write_enable; // RULE_13
	assign opcode_double_shift = in_shift & (b_field == B_OPCODE_DOUBLE_SHIFT)
		& regfile_write_enable & q_load_enable; // RULE_14
	assign freg_q_shift    = in_shift & (b_field == B_FREG_Q_SHIFT) & q_load_enable; // RULE_15
	assign fw_q_shift      = in_shift & (b_field == B_FW_Q_SHIFT) & q_load_enable;
	assign fw_rf_shift     = in_shift & (b_field == B_FW_RF_SHIFT) & regfile_write_enable;
	assign fw_double_shift = in_shift & (b_field == B_FW_DOUBLE_SHIFT)
		& regfile_write_enable & q_load_enable;
	assign q_shift  = freg_q_shift | fw_q_shift | fw_double_shift | opcode_double_shift;
	assign rf_shift = opcode_single_shift | opcode_double_shift | fw_rf_shift | fw_double_shift;

	// Opcode shift type decode
	always_comb begin
		op_kind       = SHIFT_OPEN_LEFT;
		op_double     = SHIFT_OPCODE inside {OP_DOL, OP_DOR, OP_DAL, OP_DAR};
		op_arith_left = SHIFT_OPCODE inside {OP_SAL, OP_DAL};
		unique case (SHIFT_OPCODE)
			OP_SOL, OP_DOL: op_kind = SHIFT_OPEN_LEFT;
			OP_SOR, OP_DOR: op_kind = SHIFT_OPEN_RIGHT;
			OP_SAL, OP_DAL: op_kind = SHIFT_ARITH_LEFT;
			OP_SAR, OP_DAR: op_kind = SHIFT_ARITH_RIGHT;
		endcase
	end

	// Filler select; closed and arithmetic-right shifts ignore it
	always_comb begin
		unique case (d_field) // RULE_18
			3'h0: shift_filler = 1'b0;
			3'h1: shift_filler = CONTROL_FLAG_ONE;
			3'h2: shift_filler = ~CONTROL_FLAG_FOUR;
			3'h3: shift_filler = CONTROL_FLAG_FOUR;
			3'h4: shift_filler = ALU_CARRY16;
			3'h5: shift_filler = ALU_OUT.ext[3];
			3'h6: shift_filler = ALU_OUT.data[0];
			3'h7: shift_filler = Q_REGISTER[0];
		endcase
	end

	// Register-file operand is always the ALU output, never the file itself
	always_comb begin
		sh_hi     = ALU_OUT.data; // RULE_20
		sh_lo     = Q_REGISTER;
		sh_double = 1'b0;
		sh_kind   = c_field; // RULE_16
		sh_filler = shift_filler;
		if (opcode_single_shift | opcode_double_shift) begin
			sh_kind   = op_kind;
			sh_double = opcode_double_shift;
			sh_filler = 1'b0;
		end else if (freg_q_shift) begin
			sh_hi     = Q_REGISTER;
			sh_kind   = FREG_SHIFT_KIND;
			sh_filler = 1'b0;
		end else if (fw_q_shift) begin
			sh_hi = Q_REGISTER;
		end else if (fw_double_shift) begin
			sh_double = 1'b1;
		end
	end

	scfd_shifter u_shifter (
		.hi          (sh_hi),
		.lo          (sh_lo),
		.double_word (sh_double),
		.kind        (sh_kind),
		.filler      (sh_filler),
		.res_hi      (res_hi),
		.res_lo      (res_lo),
		.bit_out     (bit_out),
		.sign_change (sign_change)
	);

	// Register-file write port
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			RF_WRITE      <= 1'b0;
			RF_WRITE_DATA <= WORD_RESET;
		end else if (CE) begin
			RF_WRITE      <= regfile_write_enable; // RULE_25
			RF_WRITE_DATA <= rf_shift ? res_hi : ALU_OUT.data; // RULE_20
		end
	end

	// Q register
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			Q_REGISTER <= WORD_RESET;
		end else if (CE && q_load_enable) begin
			if (q_shift) begin
				Q_REGISTER <= (sh_double && !freg_q_shift && !fw_q_shift) ? res_lo : res_hi;
			end else begin
				Q_REGISTER <= INTERNAL_BUS.data; // RULE_26
			end
		end
	end

	// Indicator register
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			INDICATORS <= INDICATORS_RESET;
		end else if (CE && in_indicator) begin
			unique case (b_field)
				4'h1: INDICATORS[IND_OVERFLOW] <= 1'b0; // RULE_08
				4'h2: INDICATORS[IND_OVERFLOW] <= 1'b1; // RULE_08
				4'h3: INDICATORS[IND_BIT] <= INTERNAL_BUS.data[0]; // RULE_09
				4'h4: begin
					INDICATORS[IND_OVERFLOW] <= ALU_OVERFLOW16; // RULE_08
					INDICATORS[IND_CARRY]    <= ALU_CARRY16;
				end
				4'h5: INDICATORS[IND_CARRY] <= 1'b0; // RULE_08
				4'h6: INDICATORS[IND_CARRY] <= 1'b1; // RULE_08
				4'h7: INDICATORS[IND_BIT] <= |INTERNAL_BUS.data; // RULE_09
				4'h8: begin
					INDICATORS[IND_GREATER]   <= COMPARE_16.greater; // RULE_10
					INDICATORS[IND_LESS]      <= COMPARE_16.less;
					INDICATORS[IND_UNORDERED] <= COMPARE_16.unordered;
				end
				4'h9: INDICATORS[IND_GREATER] <= 1'b0; // RULE_10
				4'hA: INDICATORS[IND_GREATER] <= 1'b1; // RULE_10
				4'hB: INDICATORS[IND_IO] <= 1'b0; // RULE_11
				4'hC: begin
					INDICATORS[IND_GREATER]   <= COMPARE_20.greater; // RULE_10
					INDICATORS[IND_LESS]      <= COMPARE_20.less;
					INDICATORS[IND_UNORDERED] <= COMPARE_20.unordered;
				end
				4'hD: INDICATORS[IND_LESS] <= 1'b0; // RULE_10
				4'hE: INDICATORS[IND_LESS] <= 1'b1; // RULE_10
				4'hF: INDICATORS[IND_IO] <= 1'b1; // RULE_11
				default: ;
			endcase
		end else if (CE && in_shift) begin
			if (b_field == B_OPCODE_SHIFT_IND_CLEAR) begin
				if (op_arith_left) begin
					INDICATORS[IND_OVERFLOW] <= 1'b0; // RULE_12
				end else begin
					INDICATORS[IND_CARRY] <= 1'b0; // RULE_12
				end
			end else if (opcode_single_shift || opcode_double_shift) begin
				// Opcode shift width must match the B code to count
				if (op_double == opcode_double_shift) begin
					if (op_arith_left && sign_change) begin
						INDICATORS[IND_OVERFLOW] <= 1'b1; // RULE_13 RULE_14
					end
					if (!op_arith_left && bit_out) begin
						INDICATORS[IND_CARRY] <= 1'b1; // RULE_13 RULE_14
					end
				end
			end
		end
	end

	// Flag three and trap; a trap event wins over its clear
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			FLAG_THREE    <= 1'b0;
			OVERFLOW_TRAP <= 1'b0;
		end else if (CE) begin
			if (d_active && d_field == D_CLEAR_FLAG_THREE) begin
				FLAG_THREE <= 1'b0; // RULE_01
			end else if (d_active && d_field == D_SET_FLAG_THREE) begin
				FLAG_THREE <= 1'b1; // RULE_01
			end
			if (OVERFLOW_TRAP_SET) begin
				OVERFLOW_TRAP <= 1'b1;
			end else if (d_active && d_field == D_CLEAR_OVERFLOW_TRAP) begin
				OVERFLOW_TRAP <= 1'b0; // RULE_01
			end
		end
	end

	// Translation errors; new errors win over the clear
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			TRANSLATION_ERRORS <= MMU_ERRORS_RESET;
		end else if (CE) begin
			if (in_mmu && b_field == B_CLEAR_TRANSLATION_ERRORS) begin
				TRANSLATION_ERRORS <= TRANSLATION_ERROR_SET; // RULE_02
			end else begin
				TRANSLATION_ERRORS <= TRANSLATION_ERRORS | TRANSLATION_ERROR_SET;
			end
		end
	end

	// Descriptor index and rings
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			DESCRIPTOR_INDEX <= DESC_INDEX_RESET;
			CURRENT_RING     <= RING_RESET;
			EFFECTIVE_RING   <= RING_RESET;
		end else if (CE && in_mmu) begin
			unique case (b_field)
				B_LOAD_DESCRIPTOR_INDEX: begin
					if (INTERNAL_BUS.ext == 4'h0) begin
						DESCRIPTOR_INDEX <= {1'b0, INTERNAL_BUS.data[0:3]}; // RULE_03
					end else begin
						DESCRIPTOR_INDEX <= {1'b1, INTERNAL_BUS.ext}; // RULE_03
					end
				end
				B_COPY_CURRENT_RING: EFFECTIVE_RING <= CURRENT_RING; // RULE_04
				B_LOAD_BOTH_RINGS: begin
					CURRENT_RING   <= INTERNAL_BUS.data[1:2]; // RULE_05
					EFFECTIVE_RING <= INTERNAL_BUS.data[1:2];
				end
				B_WRITE_SIZE_WORD, B_READ_SIZE_WORD: begin
					DESCRIPTOR_INDEX <= DESCRIPTOR_INDEX + 5'h01; // RULE_07
				end
				default: ;
			endcase
		end
	end

	// Descriptor file, no reset so it maps to plain storage
	always_ff @(posedge CLOCK) begin
		if (CE && in_mmu && b_field == B_WRITE_BASE_WORD) begin
			descriptor_file[DESCRIPTOR_INDEX][0:15] <= INTERNAL_BUS.data; // RULE_06
		end
		if (CE && in_mmu && b_field == B_WRITE_SIZE_WORD) begin
			descriptor_file[DESCRIPTOR_INDEX][16:31] <= INTERNAL_BUS.data; // RULE_07
		end
	end

	// Constant byte, other byte all ones or zeros
	always_comb begin
		if (mw[CONST_SEL_BIT]) begin
			constant_word = {{8{mw[CONST_FILL_BIT]}}, mw[CONST_FIRST:CONST_LAST]}; // RULE_21
		end else begin
			constant_word = {mw[CONST_FIRST:CONST_LAST], {8{mw[CONST_FILL_BIT]}}}; // RULE_21
		end
	end

	// Bus source: constants and descriptor reads
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			BUS_OUT_VALID <= 1'b0;
			BUS_OUT       <= '0;
		end else if (CE) begin
			BUS_OUT_VALID <= in_constant
				| (in_mmu & ((b_field == B_READ_BASE_WORD) | (b_field == B_READ_SIZE_WORD)));
			if (in_constant) begin
				BUS_OUT.data <= constant_word;
				BUS_OUT.ext  <= {4{constant_word[0]}}; // RULE_22
			end else if (in_mmu && b_field == B_READ_BASE_WORD) begin
				BUS_OUT.data <= descriptor_file[DESCRIPTOR_INDEX][0:15]; // RULE_06
				BUS_OUT.ext  <= 4'h0;
			end else if (in_mmu && b_field == B_READ_SIZE_WORD) begin
				BUS_OUT.data <= descriptor_file[DESCRIPTOR_INDEX][16:31]; // RULE_07
				BUS_OUT.ext  <= 4'h0;
			end
		end
	end

	// User codes leave the chip untouched
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			USER_CODE_VALID <= 1'b0;
			USER_CODE       <= '0;
		end else if (CE) begin
			USER_CODE_VALID <= in_user; // RULE_23
			USER_CODE       <= in_user ? mw[USER_FIRST:USER_LAST] : USER_CODE;
		end
	end

endmodule : scfd_decoder

//--- tb/scfd_decoder_props.sv
// Port-level assertions for the special control field decoder.
`timescale 1ns/1ps
module scfd_decoder_props
	import scfd_pkg::*;
(
	// Clock, reset and microword
	input wire logic         CLOCK,
	input wire logic         RST,
	input wire logic [0:47]  MICROWORD_BITS,
	input wire logic         OVERFLOW_TRAP_SET,
	// Observed outputs
	input wire logic         RF_WRITE,
	input wire logic         BUS_OUT_VALID,
	input wire scfd_bus_type BUS_OUT,
	input wire logic [0:7]   INDICATORS,
	input wire logic         FLAG_THREE,
	input wire logic         OVERFLOW_TRAP,
	input wire logic [1:0]   CURRENT_RING,
	input wire logic [1:0]   EFFECTIVE_RING,
	input wire logic [0:4]   DESCRIPTOR_INDEX,
	input wire logic         USER_CODE_VALID,
	input wire logic [0:9]   USER_CODE
);
	// Results show three edges after sampling
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	logic [2:0] a;
	logic [3:0] b;
	logic [2:0] d;
	assign a = MICROWORD_BITS[35:37];
	assign b = MICROWORD_BITS[38:41];
	assign d = MICROWORD_BITS[45:47];
	a_flag_set: assert property (a==3'h0 && b==4'h0 && d==3'h6
		|-> ##3 FLAG_THREE) else $error("flag three not set");
	a_trap_clear: assert property (a==3'h0 && b==4'h0 && d==3'h7
		|-> ##3 (!OVERFLOW_TRAP || $past(OVERFLOW_TRAP_SET))) else $error("trap not cleared");
	a_ring_copy: assert property (a==3'h1 && b==4'h2
		|-> ##3 EFFECTIVE_RING == CURRENT_RING) else $error("ring not copied");
	a_index_step: assert property (a==3'h1 && (b==4'h6 || b==4'h7)
		|-> ##3 DESCRIPTOR_INDEX == $past(DESCRIPTOR_INDEX) + 5'h01) else $error("index step");
	a_rf_write: assert property (1'b1
		|-> ##3 RF_WRITE == $past(MICROWORD_BITS[26], 3)) else $error("write enable wrong");
	a_const_out: assert property (a==3'h4
		|-> ##3 BUS_OUT_VALID && BUS_OUT.ext == {4{BUS_OUT.data[0]}}) else $error("constant");
	a_user_code: assert property (a>=3'h5
		|-> ##3 USER_CODE_VALID && USER_CODE == $past(MICROWORD_BITS[38:47], 3))
		else $error("user code wrong");
	a_user_quiet: assert property (a>=3'h5
		|-> ##3 $stable(INDICATORS) && $stable(FLAG_THREE)) else $error("user code acted");
endmodule : scfd_decoder_props
bind scfd_decoder scfd_decoder_props u_props (.*);

//--- tb/scfd_store.sv
// Microprogram store model: presents each fetched word for one cycle.
`timescale 1ns/1ps
module scfd_store (
	input  wire logic        CLOCK,
	input  wire logic [0:47] next_word,
	output logic      [0:47] word = 48'h0
);
	// Changes away from the sampling edge
	always @(negedge CLOCK) begin
		word <= next_word;
	end
endmodule : scfd_store

//--- tb/scfd_decoder_tb.sv
// Self-checking bench for the special control field decoder.
`timescale 1ns/1ps
module scfd_decoder_tb
	import scfd_pkg::*;
;
	logic             CLOCK = 1'b0;
	logic             RST = 1'b1;
	logic [0:47]      nw = 48'h0;
	logic [0:47]      mw;
	scfd_bus_type     bus = 20'h0;
	scfd_bus_type     alu = 20'h0;
	scfd_compare_type c16 = 3'h0;
	scfd_compare_type c20 = 3'h0;
	scfd_opshift_type op = OP_SOL;
	logic             cy = 1'b0;
	logic             ts = 1'b0;
	logic [3:0]       tes = 4'h0;
	logic             rfw, bv, uv, f3, trap;
	logic [0:15]      rfd, q, last_rf;
	scfd_bus_type     bo, last_bo;
	logic [0:7]       ind;
	logic [3:0]       terr;
	logic [1:0]       cr, er;
	logic [0:4]       idx;
	logic [0:9]       uc;
	int               errors = 0;
	int               n_tests = 0;
	int               cyc = 0;
	always #5 CLOCK = ~CLOCK;
	scfd_store u_store (.CLOCK(CLOCK), .next_word(nw), .word(mw));
	scfd_decoder uut (.CLOCK, .RST, .CE(1'h1), .MICROWORD_BITS(mw),
		.INTERNAL_BUS(bus), .ALU_OUT(alu), .ALU_CARRY16(cy), .ALU_OVERFLOW16(cy),
		.COMPARE_16(c16), .COMPARE_20(c20), .SHIFT_OPCODE(op), .FREG_SHIFT_KIND(3'h0),
		.CONTROL_FLAG_ONE(1'h0), .CONTROL_FLAG_FOUR(1'h0), .OVERFLOW_TRAP_SET(ts),
		.TRANSLATION_ERROR_SET(tes), .RF_WRITE(rfw), .RF_WRITE_DATA(rfd), .Q_REGISTER(q),
		.BUS_OUT_VALID(bv), .BUS_OUT(bo), .INDICATORS(ind), .FLAG_THREE(f3),
		.OVERFLOW_TRAP(trap), .TRANSLATION_ERRORS(terr), .CURRENT_RING(cr),
		.EFFECTIVE_RING(er), .DESCRIPTOR_INDEX(idx), .USER_CODE_VALID(uv), .USER_CODE(uc));
	// Data counts only while its strobe is up
	always @(posedge CLOCK) begin
		if (rfw === 1'b1) last_rf <= rfd;
		if (bv === 1'b1) last_bo <= bo;
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			errors++;
			complete_run;
		end
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
		n_tests++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask : chk
	// One word, then idle until settled
	task automatic w(input logic [2:0] a, input logic [0:9] f, input logic [1:0] en);
		@(negedge CLOCK);
		nw <= {26'h0, en, 7'h0, a, f};
		@(negedge CLOCK);
		nw <= 48'h0;
		repeat (6) @(negedge CLOCK);
	endtask : w
	task automatic wi(input logic [3:0] b, input logic [7:0] e);
		w(3'h2, {b, 6'h00}, 2'h0);
		chk("indicators", 20'(e), 20'(ind));
	endtask : wi
	task automatic t_general;
		w(3'h0, 10'h006, 2'h0);
		chk("f3", 20'h1, 20'(f3));
		w(3'h0, 10'h005, 2'h0);
		chk("f3", 20'h0, 20'(f3));
		ts = 1'b1;
		w(3'h0, 10'h146, 2'h0);
		ts = 1'b0;
		chk("inhibited f3", 20'h0, 20'(f3));
		w(3'h0, 10'h007, 2'h0);
		chk("trap", 20'h0, 20'(trap));
		$display("general test done");
	endtask : t_general
	task automatic t_mmu;
		tes = 4'hF;
		bus = 20'h0A000;
		w(3'h1, 10'h040, 2'h0);
		chk("index", 20'h0A, 20'(idx));
		tes = 4'h0;
		w(3'h1, 10'h006, 2'h0);
		chk("errors", 20'h0, 20'(terr));
		chk("f3", 20'h1, 20'(f3));
		bus = 20'h56000;
		w(3'h1, 10'h040, 2'h0);
		chk("index", 20'h15, 20'(idx));
		w(3'h1, 10'h0C0, 2'h0);
		chk("rings", 20'hF, 20'({cr, er}));
		w(3'h1, 10'h080, 2'h0);
		bus = 20'h01234;
		w(3'h1, 10'h100, 2'h0);
		bus = 20'h05678;
		w(3'h1, 10'h180, 2'h0);
		chk("index", 20'h16, 20'(idx));
		bus = 20'h50000;
		w(3'h1, 10'h040, 2'h0);
		w(3'h1, 10'h140, 2'h0);
		chk("base", 20'h01234, 20'(last_bo));
		w(3'h1, 10'h1C0, 2'h0);
		chk("size", 20'h05678, 20'(last_bo));
		chk("index", 20'h16, 20'(idx));
		$display("mmu test done");
	endtask : t_mmu
	task automatic t_ind;
		wi(4'h2, 8'h80);
		wi(4'h1, 8'h00);
		wi(4'h6, 8'h20);
		wi(4'h5, 8'h00);
		cy = 1'b1;
		wi(4'h4, 8'hA0);
		bus = 20'h08000;
		wi(4'h3, 8'hB0);
		bus = 20'h00001;
		wi(4'h7, 8'hB0);
		bus = 20'h0;
		wi(4'h7, 8'hA0);
		c16 = 3'h5;
		wi(4'h8, 8'hA5);
		c20 = 3'h2;
		wi(4'hC, 8'hA2);
		wi(4'hA, 8'hA6);
		wi(4'h9, 8'hA2);
		wi(4'hD, 8'hA0);
		wi(4'hE, 8'hA2);
		wi(4'hF, 8'hAA);
		wi(4'hB, 8'hA2);
		w(3'h2, 10'h005, 2'h0);
		chk("f3", 20'h1, 20'(f3));
		$display("indicator test done");
	endtask : t_ind
	task automatic t_shift;
		op = OP_SAL;
		w(3'h3, 10'h000, 2'h0);
		chk("indicators", 20'h22, 20'(ind));
		op = OP_SOR;
		w(3'h3, 10'h000, 2'h0);
		chk("indicators", 20'h02, 20'(ind));
		op = OP_SAL;
		alu = 20'h04000;
		w(3'h3, 10'h080, 2'h2);
		chk("indicators", 20'h82, 20'(ind));
		chk("rf data", 20'h8000, 20'(last_rf));
		op = OP_SOR;
		alu = 20'h00001;
		w(3'h3, 10'h080, 2'h2);
		chk("indicators", 20'hA2, 20'(ind));
		chk("rf data", 20'h0000, 20'(last_rf));
		bus = 20'h08001;
		w(3'h0, 10'h000, 2'h1);
		chk("q", 20'h8001, 20'(q));
		op = OP_DOL;
		w(3'h3, 10'h000, 2'h0);
		alu = 20'h08000;
		w(3'h3, 10'h0C0, 2'h3);
		chk("indicators", 20'hA2, 20'(ind));
		chk("q", 20'h0002, 20'(q));
		chk("rf data", 20'h0001, 20'(last_rf));
		w(3'h3, 10'h148, 2'h1);
		chk("q", 20'h0004, 20'(q));
		w(3'h3, 10'h162, 2'h1);
		chk("q", 20'h8002, 20'(q));
		w(3'h3, 10'h164, 2'h1);
		chk("q", 20'hC001, 20'(q));
		alu = 20'h08002;
		w(3'h3, 10'h1B0, 2'h2);
		chk("rf data", 20'hC001, 20'(last_rf));
		alu = 20'h00001;
		w(3'h3, 10'h1E8, 2'h3);
		chk("rf data", 20'h8000, 20'(last_rf));
		chk("q", 20'hE000, 20'(q));
		w(3'h3, 10'h040, 2'h1);
		chk("q", 20'hC000, 20'(q));
		$display("shift test done");
	endtask : t_shift
	task automatic t_const_user;
		w(3'h4, 10'h25A, 2'h0);
		chk("constant", 20'h0005A, 20'(last_bo));
		w(3'h4, 10'h181, 2'h0);
		chk("constant", 20'hF81FF, 20'(last_bo));
		for (int i = 5; i < 8; i++) begin
			w(3'(i), 10'(i * 37), 2'h0);
			chk("user code", 20'(i * 37), 20'(uc));
		end
		$display("constant and user test done");
	endtask : t_const_user
	initial begin
		repeat (4) @(negedge CLOCK);
		RST = 1'b0;
		t_general;
		t_mmu;
		t_ind;
		t_shift;
		t_const_user;
		complete_run;
	end
endmodule : scfd_decoder_tb
